/* File: hdl/dss_pkg.sv */
package dss_pkg;

	// ----------------------------------------------------------------
	// Word layout
	// ----------------------------------------------------------------
	localparam int unsigned WORD_W = 16;
	localparam int unsigned MODE_COUNT = 5;
	localparam int unsigned MODE_W = 3;
	localparam int unsigned CLASS_W = 3;
	localparam int unsigned STATE_NUM_W = 4;

	// Operating modes, index of each acknowledgement word
	localparam logic [2:0] MODE_JOG = 3'h0;
	localparam logic [2:0] MODE_VELOCITY = 3'h1;
	localparam logic [2:0] MODE_POSITION = 3'h2;
	localparam logic [2:0] MODE_HOMING = 3'h3;
	localparam logic [2:0] MODE_GEARING = 3'h4;

	// ----------------------------------------------------------------
	// Operating states
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		DSS_ST_INIT,
		DSS_ST_PARAM,
		DSS_ST_NOT_READY,
		DSS_ST_READY,
		DSS_ST_ENABLED,
		DSS_ST_QUICK_STOP,
		DSS_ST_FAULT_REACT,
		DSS_ST_FAULT
	} dss_state_t;

	// Numbers reported in the status word
	localparam logic [3:0] STATE_NUM_INIT = 4'h1;
	localparam logic [3:0] STATE_NUM_PARAM = 4'h2;
	localparam logic [3:0] STATE_NUM_NOT_READY = 4'h3;
	localparam logic [3:0] STATE_NUM_READY = 4'h4;
	localparam logic [3:0] STATE_NUM_ENABLED = 4'h6;
	localparam logic [3:0] STATE_NUM_QUICK_STOP = 4'h7;
	localparam logic [3:0] STATE_NUM_FAULT_REACT = 4'h8;
	localparam logic [3:0] STATE_NUM_FAULT = 4'h9;

	// ----------------------------------------------------------------
	// Drive control command values
	// ----------------------------------------------------------------
	localparam logic [15:0] CMD_DISABLE = 16'h0001;
	localparam logic [15:0] CMD_ENABLE = 16'h0002;
	localparam logic [15:0] CMD_QUICK_STOP = 16'h0004;
	localparam logic [15:0] CMD_FAULT_RESET = 16'h0008;
	localparam logic [15:0] CMD_QS_RELEASE = 16'h0010;

	// Error classes
	localparam logic [2:0] ERR_CLASS_NONE = 3'h0;
	localparam logic [2:0] ERR_CLASS_1 = 3'h1;
	localparam logic [2:0] ERR_CLASS_2 = 3'h2;
	localparam logic [2:0] ERR_CLASS_3 = 3'h3;
	localparam logic [2:0] ERR_CLASS_4 = 3'h4;

	// ----------------------------------------------------------------
	// Status word fields
	// ----------------------------------------------------------------
	localparam int unsigned STAT_NUM_LSB = 0;
	localparam int unsigned STAT_INT_FAULT_BIT = 5;
	localparam int unsigned STAT_EXT_FAULT_BIT = 6;
	localparam int unsigned STAT_WARN_BIT = 7;
	localparam int unsigned STAT_MODE_LSB = 12;
	localparam logic [15:0] STAT_RESET = 16'h0001;

	// Acknowledgement word fields
	localparam int unsigned ACK_POS_LIMIT_BIT = 0;
	localparam int unsigned ACK_NEG_LIMIT_BIT = 1;
	localparam int unsigned ACK_QS_RESPONSE_BIT = 2;
	localparam int unsigned ACK_REF_SWITCH_BIT = 3;
	localparam int unsigned ACK_SW_STOP_BIT = 7;
	localparam int unsigned ACK_SPEC_LSB = 12;
	localparam int unsigned ACK_FINISHED_BIT = 14;
	localparam int unsigned ACK_ERROR_BIT = 15;
	localparam logic [15:0] ACK_USED_MASK = 16'hF08F;
	localparam logic [15:0] ACK_RESET = 16'h0000;

	// Warning word fields
	localparam int unsigned WARN_OVERRUN_BIT = 0;
	localparam int unsigned WARN_OVERTEMP_BIT = 1;
	localparam int unsigned WARN_CURRENT_LIMIT_BIT = 5;
	localparam int unsigned WARN_POS_DEV_BIT = 9;
	localparam logic [15:0] WARN_RESET = 16'h0000;

endpackage

/* File: hdl/dss_ack_if.sv */
`timescale 1ns/1ps

interface dss_ack_if;
	logic [dss_pkg::MODE_W-1:0] active_mode;
	logic [dss_pkg::WORD_W-1:0] set_mask;
	logic clear_active;
	logic [1:0] mode_spec;
	logic [dss_pkg::WORD_W-1:0] words [dss_pkg::MODE_COUNT];

	modport ctrl
	(
		output active_mode,
		output set_mask,
		output clear_active,
		output mode_spec,
		input words
	);

	modport store
	(
		input active_mode,
		input set_mask,
		input clear_active,
		input mode_spec,
		output words
	);
endinterface

/* File: hdl/dss_ack_words.sv */
`timescale 1ns/1ps

module dss_ack_words
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Control side
	dss_ack_if.store ack
);

	// ----------------------------------------------------------------
	// One acknowledgement word per operating mode
	// ----------------------------------------------------------------
	genvar m;
	generate
		for (m = 0; m < dss_pkg::MODE_COUNT; m++)
		begin : g_mode
			logic [dss_pkg::WORD_W-1:0] word;
			logic [dss_pkg::WORD_W-1:0] next_word;
			logic sel;

			assign sel = (ack.active_mode == m[dss_pkg::MODE_W-1:0]);

			always_comb
			begin
				next_word = word;
				if (sel && ack.clear_active)
				begin
					next_word = dss_pkg::ACK_RESET;
				end
				// Set after clear so a same-cycle event survives a restart
				if (sel)
				begin
					next_word = next_word | ack.set_mask;
					next_word[dss_pkg::ACK_SPEC_LSB +: 2] = ack.mode_spec;
				end
				// Reserved bits held at zero
				next_word = next_word & dss_pkg::ACK_USED_MASK;
			end

			always_ff @(posedge clk_in or negedge rst_n_in)
			begin
				if (!rst_n_in)
				begin
					word <= dss_pkg::ACK_RESET;
				end
				else
				begin
					word <= next_word;
				end
			end

			assign ack.words[m] = word;
		end
	endgenerate

endmodule

/* File: hdl/dss_top.sv */
// Functional notes
// - Start state 1, self-test, then state 2
// - State 2 to 3 only after parameters succeed
// - State 3 to 4 on safety and supply
// - Command 2 in state 4 enables, state 6
// - Command 1 in state 6 returns to 4
// - Supply or safety loss returns to state 3
// - Command 4 or class 1/2 enters 7
// - Class 2 after quick stop goes fault path
// - Class 3/4 releases motor, states 8 then 9
// - Command 8 or 16 releases quick stop
// - Class 2/3 fault left only on 8
// - State number in status bits 0 to 3
// - Status bit 5 from internal fault flags
// - Status bit 6 from external fault flags
// - Status bit 7 from warning flags
// - Status bits 12-15 mirror active mode word
// - Acknowledge bits 0,1,2,3,7 layout
// - Class 1/2 error sets bit 15 first, 14 later
// - Class 1/2 sets bit 14 at standstill
// - Class 3 in state 6 or 7 sets 14 and 15 at once
// - States 6/7 powered, 8 reaction, 9 fault
// - Warning word bits 0, 1, 5, 9
`timescale 1ns/1ps

module dss_top
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Fieldbus command write
	input wire logic cmd_valid_in,
	input wire logic [15:0] cmd_value_in,
	// Start-up progress
	input wire logic selftest_done_in,
	input wire logic param_init_ok_in,
	// Power and safety
	input wire logic safe_disable_a_in,
	input wire logic safe_disable_b_in,
	input wire logic supply_above_threshold_in,
	input wire logic motor_standstill_in,
	// Error events
	input wire logic err_valid_in,
	input wire logic [2:0] err_class_in,
	// Monitoring flags
	input wire logic [15:0] internal_fault_flags_in,
	input wire logic [15:0] external_fault_flags_in,
	input wire logic warn_pos_overrun_in,
	input wire logic warn_amp_overtemp_in,
	input wire logic warn_current_limit_in,
	input wire logic warn_pos_deviation_in,
	// Operating mode progress
	input wire logic [2:0] active_mode_in,
	input wire logic mode_start_in,
	input wire logic mode_done_in,
	input wire logic [1:0] mode_spec_in,
	input wire logic positive_limit_error_in,
	input wire logic negative_limit_error_in,
	input wire logic ref_switch_error_in,
	// Power stage
	output logic amp_enable_out,
	output logic quick_stop_out,
	// Status words
	output logic [15:0] drive_state_status_word_out,
	output logic [15:0] warning_flags_out,
	output logic [15:0] jog_mode_acknowledge_out,
	output logic [15:0] velocity_mode_acknowledge_out,
	output logic [15:0] position_mode_acknowledge_out,
	output logic [15:0] homing_mode_acknowledge_out,
	output logic [15:0] gearing_mode_acknowledge_out
);

	// ----------------------------------------------------------------
	// Decoded events
	// ----------------------------------------------------------------
	dss_pkg::dss_state_t state;
	dss_pkg::dss_state_t next_state;
	logic [2:0] stop_class;
	logic [2:0] next_stop_class;
	logic stopped;
	logic next_stopped;
	logic [15:0] set_mask;
	logic power_ok;
	logic err_light;
	logic err_heavy;
	logic cmd_disable;
	logic cmd_enable;
	logic cmd_quick_stop;
	logic cmd_fault_reset;
	logic cmd_qs_release;

	assign power_ok = safe_disable_a_in & safe_disable_b_in & supply_above_threshold_in;
	assign err_light = err_valid_in &
		((err_class_in == dss_pkg::ERR_CLASS_1) || (err_class_in == dss_pkg::ERR_CLASS_2));
	assign err_heavy = err_valid_in &
		((err_class_in == dss_pkg::ERR_CLASS_3) || (err_class_in == dss_pkg::ERR_CLASS_4));
	assign cmd_disable = cmd_valid_in && (cmd_value_in == dss_pkg::CMD_DISABLE);
	assign cmd_enable = cmd_valid_in && (cmd_value_in == dss_pkg::CMD_ENABLE);
	assign cmd_quick_stop = cmd_valid_in && (cmd_value_in == dss_pkg::CMD_QUICK_STOP);
	assign cmd_fault_reset = cmd_valid_in && (cmd_value_in == dss_pkg::CMD_FAULT_RESET);
	assign cmd_qs_release = cmd_valid_in && (cmd_value_in == dss_pkg::CMD_QS_RELEASE);

	// ----------------------------------------------------------------
	// Operating state machine
	// ----------------------------------------------------------------
	// stop_class keeps the cause of a quick stop or fault: none means a
	// software stop, otherwise the worst error class seen so far.
	always_comb
	begin
		next_state = state;
		next_stop_class = stop_class;
		next_stopped = stopped;
		set_mask = '0;
		// Limit and reference errors are latched in whatever state
		// acknowledge bit layout
		set_mask[dss_pkg::ACK_POS_LIMIT_BIT] = positive_limit_error_in;
		set_mask[dss_pkg::ACK_NEG_LIMIT_BIT] = negative_limit_error_in;
		set_mask[dss_pkg::ACK_REF_SWITCH_BIT] = ref_switch_error_in;
		set_mask[dss_pkg::ACK_FINISHED_BIT] = mode_done_in;
		case (state)
			dss_pkg::DSS_ST_INIT:
			begin
				if (selftest_done_in)
				begin
					next_state = dss_pkg::DSS_ST_PARAM;
				end
			end
			dss_pkg::DSS_ST_PARAM:
			begin
				if (param_init_ok_in)
				begin
					next_state = dss_pkg::DSS_ST_NOT_READY;
				end
			end
			dss_pkg::DSS_ST_NOT_READY:
			begin
				if (power_ok)
				begin
					next_state = dss_pkg::DSS_ST_READY;
				end
			end
			dss_pkg::DSS_ST_READY:
			begin
				if (err_heavy)
				begin
					next_state = dss_pkg::DSS_ST_FAULT_REACT;
					next_stop_class = err_class_in;
				end
				else if (!power_ok)
				begin
					next_state = dss_pkg::DSS_ST_NOT_READY;
				end
				else if (cmd_enable)
				begin
					next_state = dss_pkg::DSS_ST_ENABLED;
				end
			end
			dss_pkg::DSS_ST_ENABLED:
			begin
				if (err_heavy)
				begin
					next_state = dss_pkg::DSS_ST_FAULT_REACT;
					next_stop_class = err_class_in;
					set_mask[dss_pkg::ACK_ERROR_BIT] = 1'b1;
					set_mask[dss_pkg::ACK_FINISHED_BIT] = 1'b1;
				end
				else if (!power_ok)
				begin
					next_state = dss_pkg::DSS_ST_NOT_READY;
				end
				else if (err_light)
				begin
					next_state = dss_pkg::DSS_ST_QUICK_STOP;
					next_stop_class = err_class_in;
					next_stopped = 1'b0;
					set_mask[dss_pkg::ACK_ERROR_BIT] = 1'b1;
					set_mask[dss_pkg::ACK_QS_RESPONSE_BIT] = 1'b1;
				end
				else if (cmd_quick_stop)
				begin
					next_state = dss_pkg::DSS_ST_QUICK_STOP;
					next_stop_class = dss_pkg::ERR_CLASS_NONE;
					next_stopped = 1'b0;
					set_mask[dss_pkg::ACK_SW_STOP_BIT] = 1'b1;
				end
				else if (cmd_disable)
				begin
					next_state = dss_pkg::DSS_ST_READY;
				end
			end
			dss_pkg::DSS_ST_QUICK_STOP:
			begin
				if (err_heavy)
				begin
					next_state = dss_pkg::DSS_ST_FAULT_REACT;
					next_stop_class = err_class_in;
					set_mask[dss_pkg::ACK_ERROR_BIT] = 1'b1;
					set_mask[dss_pkg::ACK_FINISHED_BIT] = 1'b1;
				end
				else if (!power_ok)
				begin
					next_state = dss_pkg::DSS_ST_NOT_READY;
				end
				else
				begin
					// A second light error may escalate the stop
					if (err_light && (err_class_in > stop_class))
					begin
						next_stop_class = err_class_in;
						set_mask[dss_pkg::ACK_ERROR_BIT] = 1'b1;
						set_mask[dss_pkg::ACK_QS_RESPONSE_BIT] = 1'b1;
					end
					if (!stopped && motor_standstill_in)
					begin
						next_stopped = 1'b1;
						if (next_stop_class != dss_pkg::ERR_CLASS_NONE)
						begin
							set_mask[dss_pkg::ACK_FINISHED_BIT] = 1'b1;
						end
					end
					if ((stopped || motor_standstill_in) &&
						(next_stop_class == dss_pkg::ERR_CLASS_2))
					begin
						next_state = dss_pkg::DSS_ST_FAULT_REACT;
					end
					else if (stopped && (cmd_fault_reset || cmd_qs_release))
					begin
						next_state = dss_pkg::DSS_ST_ENABLED;
						next_stop_class = dss_pkg::ERR_CLASS_NONE;
					end
				end
			end
			dss_pkg::DSS_ST_FAULT_REACT:
			begin
				next_state = dss_pkg::DSS_ST_FAULT;
			end
			dss_pkg::DSS_ST_FAULT:
			begin
				// fault reset needed; class 4 never clears
				if (cmd_fault_reset && (stop_class != dss_pkg::ERR_CLASS_4))
				begin
					next_state = dss_pkg::DSS_ST_NOT_READY;
					next_stop_class = dss_pkg::ERR_CLASS_NONE;
				end
			end
			default:
			begin
				next_state = dss_pkg::DSS_ST_INIT;
			end
		endcase
	end

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			state <= dss_pkg::DSS_ST_INIT;
			stop_class <= dss_pkg::ERR_CLASS_NONE;
			stopped <= 1'b0;
		end
		else
		begin
			state <= next_state;
			stop_class <= next_stop_class;
			stopped <= next_stopped;
		end
	end

	// ----------------------------------------------------------------
	// Acknowledgement words
	// ----------------------------------------------------------------
	dss_ack_if ack_bus ();

	assign ack_bus.active_mode = active_mode_in;
	assign ack_bus.set_mask = set_mask;
	assign ack_bus.clear_active = mode_start_in;
	assign ack_bus.mode_spec = mode_spec_in;

	dss_ack_words u_ack_words
	(
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.ack(ack_bus.store)
	);

	assign jog_mode_acknowledge_out = ack_bus.words[dss_pkg::MODE_JOG];
	assign velocity_mode_acknowledge_out = ack_bus.words[dss_pkg::MODE_VELOCITY];
	assign position_mode_acknowledge_out = ack_bus.words[dss_pkg::MODE_POSITION];
	assign homing_mode_acknowledge_out = ack_bus.words[dss_pkg::MODE_HOMING];
	assign gearing_mode_acknowledge_out = ack_bus.words[dss_pkg::MODE_GEARING];

	// ----------------------------------------------------------------
	// Status, warnings and power outputs
	// ----------------------------------------------------------------
	logic [15:0] next_status;
	logic [15:0] next_warn;
	logic [15:0] mode_word;
	logic next_amp;
	logic next_qs;

	// Unknown mode index reads as an idle word
	assign mode_word = (active_mode_in < dss_pkg::MODE_COUNT) ?
		ack_bus.words[active_mode_in] : dss_pkg::ACK_RESET;

	always_comb
	begin
		next_warn = dss_pkg::WARN_RESET;
		next_warn[dss_pkg::WARN_OVERRUN_BIT] = warn_pos_overrun_in;
		next_warn[dss_pkg::WARN_OVERTEMP_BIT] = warn_amp_overtemp_in;
		next_warn[dss_pkg::WARN_CURRENT_LIMIT_BIT] = warn_current_limit_in;
		next_warn[dss_pkg::WARN_POS_DEV_BIT] = warn_pos_deviation_in;
		next_status = '0;
		case (state)
			dss_pkg::DSS_ST_INIT: next_status[3:0] = dss_pkg::STATE_NUM_INIT;
			dss_pkg::DSS_ST_PARAM: next_status[3:0] = dss_pkg::STATE_NUM_PARAM;
			dss_pkg::DSS_ST_NOT_READY: next_status[3:0] = dss_pkg::STATE_NUM_NOT_READY;
			dss_pkg::DSS_ST_READY: next_status[3:0] = dss_pkg::STATE_NUM_READY;
			dss_pkg::DSS_ST_ENABLED: next_status[3:0] = dss_pkg::STATE_NUM_ENABLED;
			dss_pkg::DSS_ST_QUICK_STOP: next_status[3:0] = dss_pkg::STATE_NUM_QUICK_STOP;
			dss_pkg::DSS_ST_FAULT_REACT: next_status[3:0] = dss_pkg::STATE_NUM_FAULT_REACT;
			dss_pkg::DSS_ST_FAULT: next_status[3:0] = dss_pkg::STATE_NUM_FAULT;
			default: next_status[3:0] = dss_pkg::STATE_NUM_INIT;
		endcase
		next_status[dss_pkg::STAT_INT_FAULT_BIT] = |internal_fault_flags_in;
		next_status[dss_pkg::STAT_EXT_FAULT_BIT] = |external_fault_flags_in;
		next_status[dss_pkg::STAT_WARN_BIT] = |next_warn;
		next_status[dss_pkg::STAT_MODE_LSB +: 4] = mode_word[dss_pkg::ACK_SPEC_LSB +: 4];
		// amplifier on in 6 and 7
		next_amp = (state == dss_pkg::DSS_ST_ENABLED) || (state == dss_pkg::DSS_ST_QUICK_STOP);
		next_qs = (state == dss_pkg::DSS_ST_QUICK_STOP);
	end

	// Outputs follow the state register by one clock; the amplifier
	// therefore drops one clock after entering the reaction state.
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			drive_state_status_word_out <= dss_pkg::STAT_RESET;
			warning_flags_out <= dss_pkg::WARN_RESET;
			amp_enable_out <= 1'b0;
			quick_stop_out <= 1'b0;
		end
		else
		begin
			drive_state_status_word_out <= next_status;
			warning_flags_out <= next_warn;
			amp_enable_out <= next_amp;
			quick_stop_out <= next_qs;
		end
	end

endmodule

/* File: test/dss_host.sv */
`timescale 1ns/1ps

module dss_host
(
	// Clock
	input wire logic clk_in,
	// Command write towards the drive
	output logic cmd_valid_out,
	output logic [15:0] cmd_value_out
);
	initial
	begin
		cmd_valid_out = 1'b0;
		cmd_value_out = 16'h0000;
	end

	task automatic send(input logic [15:0] value, input int gap);
		@(posedge clk_in);
		cmd_valid_out <= 1'b1;
		cmd_value_out <= value;
		@(posedge clk_in);
		cmd_valid_out <= 1'b0;
		// Idle bus shows the inverse, so a stale word never passes for a command
		cmd_value_out <= ~value;
		repeat (gap) @(posedge clk_in);
	endtask
endmodule

/* File: test/dss_top_assertions.sv */
`timescale 1ns/1ps

module dss_top_assertions
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Drive inputs
	input wire logic cmd_valid_in,
	input wire logic [15:0] cmd_value_in,
	input wire logic safe_disable_a_in,
	input wire logic safe_disable_b_in,
	input wire logic supply_above_threshold_in,
	input wire logic err_valid_in,
	input wire logic [2:0] err_class_in,
	input wire logic [15:0] internal_fault_flags_in,
	input wire logic [15:0] external_fault_flags_in,
	// Drive outputs
	input wire logic amp_enable_out,
	input wire logic quick_stop_out,
	input wire logic [15:0] drive_state_status_word_out
);
	logic pwr_ok;
	logic [3:0] num;

	assign pwr_ok = safe_disable_a_in & safe_disable_b_in & supply_above_threshold_in;
	assign num = drive_state_status_word_out[3:0];

	default clocking dss_cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);

	// Status lags the state by one edge, so nothing may have moved it last cycle
	sequence settled(logic [3:0] n);
		num == n && !$past(cmd_valid_in) && !$past(err_valid_in) && $past(pwr_ok);
	endsequence

	sequence fault_walk;
		num == 4'h8 ##1 num == 4'h9;
	endsequence

	amp_state_match_a: assert property (amp_enable_out == (num == 4'h6 || num == 4'h7))
		else $error("amplifier enable disagrees with state number");
	qs_state_match_a: assert property (quick_stop_out == (num == 4'h7))
		else $error("quick stop output disagrees with state number");
	status_reserved_a: assert property ((drive_state_status_word_out & 16'h0F10)
		== 16'h0000)
		else $error("reserved status bits set");
	// Skip the edge after a reset release, where the status still holds its reset value
	int_fault_bit_a: assert property ($past(rst_n_in) &&
		$past(internal_fault_flags_in) == $past(internal_fault_flags_in, 2) |->
		drive_state_status_word_out[5] == |$past(internal_fault_flags_in))
		else $error("internal fault summary bit wrong");
	ext_fault_bit_a: assert property ($past(rst_n_in) &&
		$past(external_fault_flags_in) == $past(external_fault_flags_in, 2) |->
		drive_state_status_word_out[6] == |$past(external_fault_flags_in))
		else $error("external fault summary bit wrong");
	enable_cmd_a: assert property (settled(4'h4) ##0 (cmd_valid_in && !err_valid_in && pwr_ok
		&& cmd_value_in == dss_pkg::CMD_ENABLE) |-> ##2 num == 4'h6)
		else $error("enable command did not reach state 6");
	power_loss_a: assert property (settled(4'h6) ##0 (!pwr_ok && !err_valid_in)
		|-> ##2 num == 4'h3)
		else $error("power loss did not return to state 3");
	class3_fault_a: assert property (settled(4'h6) ##0 (err_valid_in
		&& err_class_in == dss_pkg::ERR_CLASS_3) |-> ##2 fault_walk)
		else $error("class 3 error did not walk states 8 and 9");
endmodule

bind dss_top dss_top_assertions u_dss_chk (.*);

/* File: test/testbench.sv */
`timescale 1ns/1ps

module testbench;
	logic clk_in, rst_n_in, cmd_valid_in, selftest_done_in, param_init_ok_in;
	logic safe_disable_a_in, safe_disable_b_in, supply_above_threshold_in, motor_standstill_in;
	logic err_valid_in, warn_pos_overrun_in, warn_amp_overtemp_in, warn_current_limit_in;
	logic warn_pos_deviation_in, mode_start_in, mode_done_in, positive_limit_error_in;
	logic negative_limit_error_in, ref_switch_error_in, amp_enable_out, quick_stop_out;
	logic [15:0] cmd_value_in, internal_fault_flags_in, external_fault_flags_in;
	logic [15:0] drive_state_status_word_out, warning_flags_out, jog_mode_acknowledge_out;
	logic [15:0] velocity_mode_acknowledge_out, position_mode_acknowledge_out;
	logic [15:0] homing_mode_acknowledge_out, gearing_mode_acknowledge_out;
	logic [2:0] err_class_in, active_mode_in;
	logic [1:0] mode_spec_in;
	logic [15:0] exp_ack [5];
	logic [31:0] rng;
	int exp_state, n_mismatch, check_count, cycles, i, m;
	int cv [10] = '{1, 2, 2, 1, 2, 4, 16, 16, 4, 8};
	int ce [10] = '{4, 6, 6, 4, 6, 7, 7, 6, 7, 6};
	logic [9:0] ss = 10'h280;

	dss_top DUT (.*);
	dss_host u_host (.clk_in(clk_in), .cmd_valid_out(cmd_valid_in), .cmd_value_out(cmd_value_in));

	initial clk_in = 1'b0;
	always #20 clk_in = ~clk_in;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	task automatic end_sim;
		$display("Comparisons %0d, mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic cmp(input logic ok, input string what);
		check_count++;
		if (ok !== 1'b1)
		begin
			n_mismatch++;
			$display("MISMATCH %0t %s", $time, what);
		end
	endtask

	task automatic check;
		logic [15:0] w [5];
		logic [15:0] sw;
		logic [15:0] wf;
		w = '{jog_mode_acknowledge_out, velocity_mode_acknowledge_out,
			position_mode_acknowledge_out, homing_mode_acknowledge_out,
			gearing_mode_acknowledge_out};
		sw = {8'h00, |{warn_pos_deviation_in, warn_current_limit_in, warn_amp_overtemp_in,
			warn_pos_overrun_in}, |external_fault_flags_in, |internal_fault_flags_in, 1'b0,
			exp_state[3:0]};
		// Mode indices past the last mode mirror an idle word
		sw[15:12] = (active_mode_in < 3'h5) ? exp_ack[active_mode_in][15:12] : 4'h0;
		wf = {6'h00, warn_pos_deviation_in, 3'h0, warn_current_limit_in, 3'h0,
			warn_amp_overtemp_in, warn_pos_overrun_in};
		cmp(drive_state_status_word_out === sw, "status word");
		cmp(amp_enable_out === (exp_state == 6 || exp_state == 7), "amp enable");
		cmp(quick_stop_out === (exp_state == 7), "quick stop");
		cmp(warning_flags_out === wf, "warning word");
		for (int k = 0; k < 5; k++)
			cmp(w[k] === exp_ack[k], "acknowledge word");
		$display("Step done at %0t, state %0d", $time, exp_state);
	endtask

	// Waits out the transition, bounded, then compares everything
	task automatic settle;
		repeat (3) @(negedge clk_in);
		for (int k = 0; k < 10 && drive_state_status_word_out[3:0] !== exp_state[3:0]; k++)
			@(negedge clk_in);
		check();
	endtask

	task automatic err(input logic [2:0] c);
		@(posedge clk_in);
		err_valid_in <= 1'b1;
		err_class_in <= c;
		@(posedge clk_in);
		err_valid_in <= 1'b0;
	endtask

	task automatic ev(input logic [4:0] v);
		@(posedge clk_in);
		{mode_start_in, mode_done_in, positive_limit_error_in, negative_limit_error_in,
			ref_switch_error_in} <= v;
		@(posedge clk_in);
		{mode_start_in, mode_done_in, positive_limit_error_in, negative_limit_error_in,
			ref_switch_error_in} <= 5'h00;
	endtask

	task automatic send(input logic [15:0] v, input int e);
		u_host.send(v, 0);
		exp_state = e;
		settle();
	endtask

	always @(posedge clk_in)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			n_mismatch++;
			end_sim();
		end
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		{rst_n_in, selftest_done_in, param_init_ok_in, safe_disable_a_in, safe_disable_b_in,
			supply_above_threshold_in, motor_standstill_in, err_valid_in, err_class_in,
			internal_fault_flags_in, external_fault_flags_in, warn_pos_overrun_in,
			warn_amp_overtemp_in, warn_current_limit_in, warn_pos_deviation_in, active_mode_in,
			mode_spec_in, mode_start_in, mode_done_in, positive_limit_error_in,
			negative_limit_error_in, ref_switch_error_in} = '0;
		exp_ack = '{default: 16'h0000};
		rng = 32'h8b10_3a1d;
		exp_state = 1;
		repeat (6) @(posedge clk_in);
		cmp(drive_state_status_word_out === 16'h0001, "reset status");
		rst_n_in <= 1'b1;
		settle();
		@(posedge clk_in) selftest_done_in <= 1'b1;
		exp_state = 2;
		settle();
		@(posedge clk_in) param_init_ok_in <= 1'b1;
		exp_state = 3;
		settle();
		@(posedge clk_in) {safe_disable_a_in, supply_above_threshold_in} <= 2'b11;
		settle();
		@(posedge clk_in) safe_disable_b_in <= 1'b1;
		exp_state = 4;
		settle();
		for (i = 0; i < 10; i++)
		begin
			@(posedge clk_in) motor_standstill_in <= ss[i];
			if (cv[i] == 4)
				exp_ack[0][7] = 1'b1;
			send(cv[i][15:0], ce[i]);
		end
		@(posedge clk_in) active_mode_in <= 3'h1;
		for (i = 1; i < 3; i++)
		begin
			@(posedge clk_in) motor_standstill_in <= 1'b0;
			ev(5'h10);
			exp_ack[1] = 16'h8004;
			err(i[2:0]);
			exp_state = 7;
			settle();
			@(posedge clk_in) motor_standstill_in <= 1'b1;
			exp_ack[1][14] = 1'b1;
			exp_state = (i == 1) ? 7 : 9;
			settle();
			send(16'h0010, (i == 1) ? 6 : 9);
		end
		@(posedge clk_in) motor_standstill_in <= 1'b0;
		send(16'h0008, 4);
		send(16'h0002, 6);
		@(posedge clk_in) active_mode_in <= 3'h2;
		ev(5'h10);
		err(3'h3);
		exp_ack[2] = 16'hC000;
		exp_state = 9;
		settle();
		send(16'h0008, 4);
		send(16'h0002, 6);
		@(posedge clk_in) supply_above_threshold_in <= 1'b0;
		exp_state = 3;
		settle();
		@(posedge clk_in) supply_above_threshold_in <= 1'b1;
		exp_state = 4;
		settle();
		err(3'h1);
		settle();
		for (i = 0; i < 12; i++)
		begin
			rng = xs(rng);
			m = rng[7:0] % 5;
			@(posedge clk_in);
			active_mode_in <= m[2:0];
			mode_spec_in <= rng[9:8];
			internal_fault_flags_in <= rng[10] ? rng[31:16] : 16'h0000;
			external_fault_flags_in <= rng[11] ? ~rng[31:16] : 16'h0000;
			{warn_pos_overrun_in, warn_amp_overtemp_in, warn_current_limit_in,
				warn_pos_deviation_in} <= rng[15:12];
			ev(rng[20:16]);
			exp_ack[m] = (rng[20] ? 16'h0000 : exp_ack[m]) |
				{1'b0, rng[19], 10'h000, rng[16], 1'b0, rng[17], rng[18]};
			exp_ack[m][13:12] = rng[9:8];
			settle();
		end
		@(posedge clk_in) active_mode_in <= 3'h7;
		settle();
		@(posedge clk_in) active_mode_in <= m[2:0];
		send(16'h0002, 6);
		err(3'h4);
		exp_ack[m][15:14] = 2'b11;
		exp_state = 9;
		settle();
		send(16'h0008, 9);
		// A class 4 fault is left only through a reset
		@(posedge clk_in) rst_n_in <= 1'b0;
		@(negedge clk_in) cmp(drive_state_status_word_out === 16'h0001, "reset status");
		@(posedge clk_in) rst_n_in <= 1'b1;
		exp_ack = '{default: 16'h0000};
		exp_ack[m][13:12] = mode_spec_in;
		exp_state = 4;
		settle();
		end_sim();
	end
endmodule
